/* rtl/ccr_pkg.sv */
package ccr_pkg;

	// Current codes: 1 LSB = 10 mA of measured output current
	localparam int          CUR_W          = 12;
	localparam logic [11:0] CUR_STEP1      = 12'h118; // 2.8 A
	localparam logic [11:0] CUR_STEP2      = 12'h154; // 3.4 A
	localparam logic [11:0] CUR_STEP3      = 12'h19A; // 4.1 A
	localparam logic [11:0] CUR_STEP4      = 12'h208; // 5.2 A
	localparam logic [11:0] CUR_STEP5      = 12'h294; // 6.6 A
	localparam logic [11:0] CUR_OVER       = 12'h2B5; // 105 % of 6.6 A = 6.93 A
	localparam logic [11:0] CUR_OPEN       = 12'h096; // 1.5 A

	// Gate drive: conduction fraction, 0 = none, max = full cycle
	localparam int          GATE_W         = 10;
	localparam logic [9:0]  GATE_MAX       = 10'h3FF;
	localparam logic [9:0]  GATE_RESET     = 10'h000;

	// Step selector codes; 0 means OFF
	localparam logic [2:0]  STEP_OFF       = 3'h0;
	localparam logic [2:0]  STEP_TOP       = 3'h5;

	// Timing, clock at 250 MHz
	localparam int          CLK_HZ         = 250_000_000;
	localparam int          OPEN_TRIP_MS   = 1000;
	localparam int          OPEN_TRIP_CYC  = CLK_HZ / 1000 * OPEN_TRIP_MS;
	localparam int          AUTO_DWELL_MS  = 2000;
	localparam int          AUTO_DWELL_CYC = CLK_HZ / 1000 * AUTO_DWELL_MS;
	localparam int          OC_SAMPLES     = 8;
	localparam int          TOL_PERMIL     = 10; // +-1 %

	// Supervisor states
	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_RUN  = 3'b010,
		ST_TRIP = 3'b100
	} sup_state_t;

	// Target current for a step code
	function automatic logic [11:0] step_target(input logic [2:0] s);
		case (s)
			3'h1:    step_target = CUR_STEP1;
			3'h2:    step_target = CUR_STEP2;
			3'h3:    step_target = CUR_STEP3;
			3'h4:    step_target = CUR_STEP4;
			3'h5:    step_target = CUR_STEP5;
			default: step_target = 12'h000;
		endcase
	endfunction

endpackage

/* rtl/ccr_sample_filter.sv */
module ccr_sample_filter
	import ccr_pkg::*;
#(
	parameter int COUNT = OC_SAMPLES
)(
	input  wire logic ref_clk_i, // Controller clock
	input  wire logic nrst_i,    // Async reset, active low
	input  wire logic clr_i,     // Restart the run count
	input  wire logic sample_i,  // New sample strobe
	input  wire logic cond_i,    // Condition seen on this sample
	output logic      hit_o      // Condition held COUNT samples
);

	logic [7:0] run_reg;
	logic [7:0] run_next;
	logic       hit_next;
	logic       hit_reg;

	// Count consecutive samples; one clean sample restarts it
	always_comb
	begin
		run_next = run_reg;
		hit_next = hit_reg;
		if (clr_i)
		begin
			run_next = 8'h00;
			hit_next = 1'b0;
		end
		else if (sample_i)
		begin
			if (!cond_i)
			begin
				run_next = 8'h00;
				hit_next = 1'b0;
			end
			else if (run_reg < 8'(COUNT))
				run_next = run_reg + 8'h01;
			hit_next = cond_i && (run_reg + 8'h01 >= 8'(COUNT));
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			run_reg <= 8'h00;
			hit_reg <= 1'b0;
		end
		else
		begin
			run_reg <= run_next;
			hit_reg <= hit_next;
		end
	end

	assign hit_o = hit_reg;

endmodule

/* rtl/series_current_fault_guard.sv */
// Overview of operation
// - Steps one to five target 2.8, 3.4, 4.1, 5.2 and 6.6 A.
// - Feedback current continually trims gate drive toward the selected step target.
// - More conduction gives less output: raise drive when current is high.
// - Current within one percent of target is held; drive stops moving.
// - Overcurrent is current above 105 percent of 6.6 A.
// - An overcurrent trip drops main relay drive.
// - Brief overcurrent excursions are ignored; only a sustained excess trips.
// - Current below 1.5 A drops relay drive within one second.
// - After a trip relay stays off until OFF selected or power reset.
// - Relay drive output is asserted during normal operation.
// - Display mode can step automatically through all levels in sequence.
// - Measured current is presented to the operator display.
// - Only front-panel rotary and display selections are accepted.
module series_current_fault_guard
	import ccr_pkg::*;
#(
	parameter int OC_COUNT   = OC_SAMPLES,     // Samples to confirm overcurrent
	parameter int OPEN_CYC   = OPEN_TRIP_CYC,  // Open circuit trip time in cycles
	parameter int DWELL_CYC  = AUTO_DWELL_CYC  // Dwell per level in auto cycling
)(
	input  wire logic        ref_clk_i,             // 250 MHz controller clock
	input  wire logic        nrst_i,                // Async power-on reset, active low
	input  wire logic [2:0]  rotary_step_i,         // Rotary switch step, 0 = OFF
	input  wire logic        display_selected_mode_i, // Step taken from display
	input  wire logic [2:0]  display_step_i,        // Display step, 0 = OFF
	input  wire logic        display_auto_i,        // Display auto-cycle mode
	input  wire logic        sample_valid_i,        // New current sample strobe
	input  wire logic [11:0] sample_current_i,      // Transformer current, 10 mA LSB
	output logic             relay_drive_o,         // Main relay coil drive
	output logic [9:0]       thyristor_gate_o,      // Gate conduction fraction
	output logic [11:0]      operator_display_o,    // Displayed output current
	output logic [2:0]       active_step_o,         // Step being regulated
	output logic             oc_fault_o,            // Overcurrent trip latched
	output logic             open_fault_o           // Open circuit trip latched
);

	////////////////////////////////////////////////////////////////
	// Step selection

	sup_state_t  state_reg, state_next;
	logic [2:0]  auto_reg, auto_next;
	logic [31:0] dwell_reg, dwell_next;
	logic [2:0]  sel_step;
	logic [11:0] target;

	// Front panel only; no remote path exists
	always_comb
	begin
		if (!display_selected_mode_i)
			sel_step = rotary_step_i;
		else if (display_auto_i)
			sel_step = auto_reg;
		else
			sel_step = display_step_i;
		if (sel_step > STEP_TOP)
			sel_step = STEP_OFF;
		target = step_target(sel_step);
	end

	a_target_map: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		sel_step == 3'h5 |-> target == CUR_STEP5) else $error("step five target wrong");

	// Auto cycling walks 1..5 and wraps
	always_comb
	begin
		auto_next  = auto_reg;
		dwell_next = dwell_reg;
		if (!(display_selected_mode_i && display_auto_i))
		begin
			auto_next  = 3'h1;
			dwell_next = 32'h0;
		end
		else if (dwell_reg >= 32'(DWELL_CYC - 1))
		begin
			dwell_next = 32'h0;
			auto_next  = (auto_reg == STEP_TOP) ? 3'h1 : auto_reg + 3'h1;
		end
		else
			dwell_next = dwell_reg + 32'h1;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			auto_reg  <= 3'h1;
			dwell_reg <= 32'h0;
		end
		else
		begin
			auto_reg  <= auto_next;
			dwell_reg <= dwell_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Fault detection

	logic        oc_now;
	logic        oc_hit;
	logic        open_now;
	logic [31:0] open_reg, open_next;
	logic        open_hit;
	logic        run_clr;

	assign oc_now   = sample_current_i > CUR_OVER;
	assign open_now = sample_current_i < CUR_OPEN;
	assign run_clr  = (state_reg != ST_RUN);

	// Sustained excess only, so load switching spikes pass
	ccr_sample_filter #(
		.COUNT (OC_COUNT)
	) u_oc_filter (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.clr_i     (run_clr),
		.sample_i  (sample_valid_i),
		.cond_i    (oc_now),
		.hit_o     (oc_hit)
	);

	a_oc_needs_run: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		$rose(oc_hit) |-> $past(sample_valid_i) && $past(oc_now))
		else $error("overcurrent confirmed without samples");
	a_oc_level: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		sample_valid_i && sample_current_i <= CUR_OVER |=> !oc_hit)
		else $error("overcurrent confirmed at or below limit");

	// Open circuit timer; the latest sample decides and is held between strobes
	logic open_seen_reg, open_seen_next;
	always_comb
	begin
		open_seen_next = open_seen_reg;
		if (run_clr)
			open_seen_next = 1'b0;
		else if (sample_valid_i)
			open_seen_next = open_now;
		open_next = (run_clr || !open_seen_reg) ? 32'h0 : open_reg + 32'h1;
		open_hit  = open_seen_reg && (open_reg >= 32'(OPEN_CYC - 2));
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			open_reg      <= 32'h0;
			open_seen_reg <= 1'b0;
		end
		else
		begin
			open_reg      <= open_next;
			open_seen_reg <= open_seen_next;
		end
	end

	a_open_timer: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_RUN && open_reg >= 32'(OPEN_CYC) |-> 1'b0)
		else $error("open circuit not tripped in time");

	////////////////////////////////////////////////////////////////
	// Supervisor and relay

	logic oc_f_reg, oc_f_next;
	logic op_f_reg, op_f_next;
	logic relay_reg, relay_next;
	logic [2:0] act_reg, act_next;

	// Trip latches until OFF; power cycle arrives as nrst_i
	always_comb
	begin
		state_next = state_reg;
		oc_f_next  = oc_f_reg;
		op_f_next  = op_f_reg;
		unique case (state_reg)
			ST_OFF:
			begin
				if (sel_step != STEP_OFF)
				begin
					state_next = ST_RUN;
					oc_f_next  = 1'b0;
					op_f_next  = 1'b0;
				end
			end
			ST_RUN:
			begin
				if (sel_step == STEP_OFF)
					state_next = ST_OFF;
				else if (oc_hit || open_hit)
				begin
					state_next = ST_TRIP;
					oc_f_next  = oc_hit;
					op_f_next  = open_hit;
				end
			end
			ST_TRIP:
			begin
				if (sel_step == STEP_OFF)
					state_next = ST_OFF;
			end
			default: state_next = ST_OFF;
		endcase
		relay_next = (state_next == ST_RUN);
		act_next   = (state_next == ST_RUN) ? sel_step : STEP_OFF;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_reg <= ST_OFF;
			oc_f_reg  <= 1'b0;
			op_f_reg  <= 1'b0;
			relay_reg <= 1'b0;
			act_reg   <= STEP_OFF;
		end
		else
		begin
			state_reg <= state_next;
			oc_f_reg  <= oc_f_next;
			op_f_reg  <= op_f_next;
			relay_reg <= relay_next;
			act_reg   <= act_next;
		end
	end

	a_oc_trip_drop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		$rose(oc_f_reg) |-> !relay_reg) else $error("relay still driven after overcurrent trip");
	a_trip_holds_off: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_TRIP && sel_step != STEP_OFF |=> !relay_reg)
		else $error("relay re-energised without OFF");
	a_relay_run: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		relay_reg == (state_reg == ST_RUN)) else $error("relay drive disagrees with run state");

	////////////////////////////////////////////////////////////////
	// Regulation loop

	logic [9:0]  gate_reg, gate_next;
	logic [11:0] disp_reg, disp_next;
	logic [21:0] band;
	logic [21:0] meas_k;
	logic [21:0] tgt_k;

	// Deadband of one percent avoids hunting around the target
	always_comb
	begin
		band      = 22'(target) * 22'(TOL_PERMIL);
		meas_k    = 22'(sample_current_i) * 22'd1000;
		tgt_k     = 22'(target) * 22'd1000;
		gate_next = gate_reg;
		disp_next = disp_reg;
		if (sample_valid_i)
			disp_next = sample_current_i;
		if (state_reg != ST_RUN)
			gate_next = GATE_RESET;
		else if (sample_valid_i)
		begin
			if (meas_k > tgt_k + band && gate_reg != GATE_MAX)
				gate_next = gate_reg + 10'h001;
			else if (meas_k + band < tgt_k && gate_reg != GATE_RESET)
				gate_next = gate_reg - 10'h001;
			else
				gate_next = gate_reg;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			gate_reg <= GATE_RESET;
			disp_reg <= 12'h000;
		end
		else
		begin
			gate_reg <= gate_next;
			disp_reg <= disp_next;
		end
	end

	// Above the trip level every target is exceeded by more than the band
	a_gate_sense: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		state_reg == ST_RUN && sample_valid_i && sample_current_i > CUR_OVER && gate_reg != GATE_MAX
		|=> gate_reg == $past(gate_reg) + 10'h001)
		else $error("gate not raised on high current");
	a_display: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		sample_valid_i |=> operator_display_o == $past(sample_current_i))
		else $error("display not updated");

	assign relay_drive_o      = relay_reg;
	assign thyristor_gate_o   = gate_reg;
	assign operator_display_o = disp_reg;
	assign active_step_o      = act_reg;
	assign oc_fault_o         = oc_f_reg;
	assign open_fault_o       = op_f_reg;

endmodule

/* tb/series_plant.sv */
module series_plant
(
	input  wire logic        ref_clk_i,   // Controller clock
	input  wire logic        nrst_i,      // Reset, active low
	input  wire logic        relay_i,     // Relay coil drive
	input  wire logic [9:0]  gate_i,      // Gate conduction
	input  wire logic        force_i,     // Bench fault current on
	input  wire logic [11:0] force_cur_i, // Bench fault current
	output logic             strobe_o,    // Sample strobe
	output logic [11:0]      cur_o        // Sampled current
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] div_reg;

	// Sample every fourth cycle; a dead relay gives no current at all
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			div_reg  <= 2'h0;
			strobe_o <= 1'b0;
			cur_o    <= 12'h000;
		end
		else
		begin
			div_reg  <= div_reg + 2'h1;
			strobe_o <= (div_reg == 2'h3);
			cur_o    <= !relay_i ? 12'h000 : force_i ? force_cur_i : 12'h2A0 - {2'h0, gate_i};
		end
	end
endmodule

/* tb/series_current_fault_guard_bench.sv */
module series_current_fault_guard_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ccr_pkg::*;

	localparam int OPEN_T  = 100;
	localparam int DWELL_T = 50;

	logic        clk;
	logic        nrst;
	logic [2:0]  rotary;
	logic        dmode;
	logic [2:0]  dstep;
	logic        dauto;
	logic        strobe;
	logic [11:0] cur;
	logic        relay;
	logic [9:0]  gate;
	logic [11:0] disp;
	logic [2:0]  step;
	logic        oc;
	logic        open;
	logic        fault_on;
	logic [11:0] fcur;
	int          n_errors = 0;
	int          tests_run = 0;

	////////////////////////////////////////////////////////////////
	series_current_fault_guard #(.OPEN_CYC(OPEN_T), .DWELL_CYC(DWELL_T)) dut
	(
		.ref_clk_i(clk), .nrst_i(nrst), .rotary_step_i(rotary), .display_selected_mode_i(dmode),
		.display_step_i(dstep), .display_auto_i(dauto), .sample_valid_i(strobe), .sample_current_i(cur),
		.relay_drive_o(relay), .thyristor_gate_o(gate), .operator_display_o(disp), .active_step_o(step),
		.oc_fault_o(oc), .open_fault_o(open)
	);

	series_plant plant
	(
		.ref_clk_i(clk), .nrst_i(nrst), .relay_i(relay), .gate_i(gate),
		.force_i(fault_on), .force_cur_i(fcur), .strobe_o(strobe), .cur_o(cur)
	);

	// Free running clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Count strobes that carried the forced current
	task automatic hi(input int n);
		int c;
		c = 0;
		while (c < n)
		begin
			@(negedge clk);
			if (strobe && cur === fcur)
				c++;
		end
	endtask

	task automatic wrap_up;
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk({relay, oc, open, step}, 12'h000, "reset flags");
		chk(12'(gate), 12'h000, "reset gate");
		chk(disp, 12'h000, "reset display");
	endtask

	// Display path only counts in display mode; codes above five mean OFF
	task automatic t_select;
		dstep = 3'h2;
		cyc(3);
		chk(12'(relay), 12'h000, "display ignored");
		dmode = 1'b1;
		cyc(3);
		chk(12'(step), 12'h002, "display step");
		dmode = 1'b0;
		rotary = 3'h6;
		cyc(3);
		chk(12'(relay), 12'h000, "step six");
	endtask

	// Walk down from five so the gate must keep rising
	task automatic t_steps;
		int         tgt [1:5];
		int         d;
		logic [9:0] g;
		tgt = '{280, 340, 410, 520, 660};
		g = 10'h000;
		for (int k = 5; k >= 1; k--)
		begin
			rotary = 3'(k);
			cyc(2);
			chk({relay, 8'h00, step}, {1'b1, 8'h00, 3'(k)}, "step taken");
			cyc(2000);
			d = int'(disp) - tgt[k];
			chk(12'((d < 0 ? -d : d) * 100 <= tgt[k]), 12'h001, "band");
			chk(12'(gate > g), 12'h001, "gate sense");
			g = gate;
			cyc(40);
			chk(12'(gate), 12'(g), "gate held");
		end
	endtask

	task automatic t_oc;
		rotary = 3'h5;
		fault_on = 1'b1;
		fcur = 12'h2B5;
		hi(10);
		chk(12'(oc), 12'h000, "at limit");
		chk(disp, 12'h2B5, "display");
		fcur = 12'h2B6;
		hi(7);
		fcur = 12'h200;
		hi(2);
		chk(12'(relay), 12'h001, "short excess");
		fcur = 12'h2B6;
		hi(8);
		cyc(3);
		chk({relay, oc}, 12'h001, "oc trip");
		rotary = 3'h4;
		cyc(5);
		chk(12'(relay), 12'h000, "latched");
		fault_on = 1'b0;
		rotary = 3'h0;
		cyc(2);
		rotary = 3'h5;
		cyc(3);
		chk({relay, oc}, 12'h002, "off clears");
	endtask

	// Boundary current holds; one count below trips inside the window
	task automatic t_open;
		fault_on = 1'b1;
		fcur = 12'h096;
		cyc(300);
		chk(12'(relay), 12'h001, "at limit");
		fcur = 12'h095;
		hi(1);
		cyc(OPEN_T + 8);
		chk({relay, open}, 12'h001, "open trip");
		nrst = 1'b0;
		fault_on = 1'b0;
		cyc(3);
		chk(12'(relay), 12'h000, "power off");
		nrst = 1'b1;
		cyc(3);
		chk({relay, open}, 12'h002, "power back");
	endtask

	task automatic t_auto;
		rotary = 3'h0;
		cyc(3);
		dmode = 1'b1;
		dauto = 1'b1;
		cyc(DWELL_T / 2);
		for (int k = 1; k <= 5; k++)
		begin
			chk(12'(step), 12'(k), "auto step");
			cyc(DWELL_T);
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		nrst = 1'b0;
		rotary = 3'h0;
		dmode = 1'b0;
		dstep = 3'h0;
		dauto = 1'b0;
		fault_on = 1'b0;
		fcur = 12'h000;
		cyc(12);
		nrst = 1'b1;
		t_reset;
		t_select;
		t_steps;
		t_oc;
		t_open;
		t_auto;
		wrap_up;
	end

	// Whole run needs some 11k cycles; allow well over three times that
	initial
	begin
		#200us;
		n_errors++;
		wrap_up;
	end
endmodule
